// ### adbc_top.sv
// Overview of operation
// - each converter path: data register, one-word buffer, then data memory.
// - finished result copied to empty buffer at once.
// - full buffer written to memory in first granted cycle with no write issued the cycle before; buffer 0 wins when both full.
// - no new result enters buffer before old contents are written.
// - conversion done while buffer full sets that converter's warning flag.
// - second result overwrites data register and sets overflow error flag.
// - mode bit 0 selects mode 0, 1 selects mode 1.
// - converter-1 error flag reads 1 after loss until software writes 0.
// - converter-0 error flag reads 1 after loss until software writes 0.
// - warning flags read 1 after warning until software clears them.
// - completion flag set when operations finish and unit returns idle.
// - warnings cause interrupt only while warning enable set.
// - interrupt request raised whenever an enabled flag condition occurs.
`timescale 1ns/1ps
`default_nettype none
module adbc_top (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    // special function register port
    input  wire adbc_pkg::adbc_sfr_t           i_sfr,
    output logic [7:0]                         o_sfr_rdata,
    // converter results
    input  wire logic                          i_conv0_ready,
    input  wire logic [adbc_pkg::DATA_W-1:0]   i_conv0_data,
    input  wire logic                          i_conv1_ready,
    input  wire logic [adbc_pkg::DATA_W-1:0]   i_conv1_data,
    // sequencer status and memory address
    input  wire logic                          i_ops_done,
    input  wire logic [adbc_pkg::ADDR_W-1:0]   i_start_addr,
    // data memory write port
    input  wire logic                          i_mem_grant,
    output adbc_pkg::adbc_mem_t                o_mem,
    // status
    output logic                               o_busy,
    output adbc_pkg::adbc_mode_t               o_mode,
    output logic                               o_irq
);
    logic [7:0]                       ctrl_reg;
    logic [7:0]                       ctrl_next;
    logic                             busy_reg;
    logic [adbc_pkg::ADDR_W-1:0]      addr_reg;
    logic                             pend_reg;
    logic                             sel_reg;
    adbc_pkg::adbc_mem_t              mem_reg;
    logic [7:0]                       rdata_reg;
    logic                             irq_reg;

    logic [1:0]                       ready;
    logic [1:0]                       full;
    logic [1:0]                       taken;
    logic [1:0]                       warn;
    logic [1:0]                       err;
    logic [adbc_pkg::DATA_W-1:0]      bufd [2];

    assign ready = {i_conv1_ready, i_conv0_ready};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            adbc_chan u_chan (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_run   (busy_reg),
                .i_ready (ready[g]),
                .i_data  ((g == 0) ? i_conv0_data : i_conv1_data),
                .i_taken (taken[g]),
                .o_full  (full[g]),
                .o_buf   (bufd[g]),
                .o_warn  (warn[g]),
                .o_err   (err[g])
            );
        end
    endgenerate

    // memory arbitration between the two buffers
    wire issue     = busy_reg && i_mem_grant && (full != 2'b00) && !pend_reg;
    wire pick      = full[0] ? 1'b0 : 1'b1;
    assign taken   = issue ? (pick ? 2'b10 : 2'b01) : 2'b00;

    // register decode
    wire ctrl_hit  = i_sfr.wr && (i_sfr.addr == adbc_pkg::CTRL_ADDR);
    wire start     = ctrl_hit && i_sfr.wdata[adbc_pkg::BIT_ENABLE] && !busy_reg;
    wire stop      = ctrl_hit && !i_sfr.wdata[adbc_pkg::BIT_ENABLE];
    wire finish    = busy_reg && i_ops_done && (full == 2'b00) && !pend_reg;
    wire warn_irq  = ctrl_reg[adbc_pkg::BIT_WARN_EN] &&
                     (ctrl_reg[adbc_pkg::BIT_WARN1] || ctrl_reg[adbc_pkg::BIT_WARN0]);
    wire irq_next  = ctrl_reg[adbc_pkg::BIT_COMPLETE] || ctrl_reg[adbc_pkg::BIT_ERR1] ||
                     ctrl_reg[adbc_pkg::BIT_ERR0] || warn_irq;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_hit) begin
            ctrl_next = i_sfr.wdata;
        end
        ctrl_next[adbc_pkg::BIT_ENABLE] = (busy_reg || start) && !stop && !finish;
        if (finish) begin
            ctrl_next[adbc_pkg::BIT_COMPLETE] = 1'b1;
        end
        if (err[1]) begin
            ctrl_next[adbc_pkg::BIT_ERR1] = 1'b1;
        end
        if (err[0]) begin
            ctrl_next[adbc_pkg::BIT_ERR0] = 1'b1;
        end
        if (warn[1]) begin
            ctrl_next[adbc_pkg::BIT_WARN1] = 1'b1;
        end
        if (warn[0]) begin
            ctrl_next[adbc_pkg::BIT_WARN0] = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_reg <= adbc_pkg::CTRL_RESET;
            busy_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            busy_reg <= ctrl_next[adbc_pkg::BIT_ENABLE];
        end
    end

    // memory write port
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mem_reg  <= '0;
            addr_reg <= '0;
            pend_reg <= 1'b0;
            sel_reg  <= 1'b0;
        end else begin
            pend_reg    <= issue;
            sel_reg     <= pick;
            mem_reg.req <= issue;
            if (issue) begin
                mem_reg.addr <= addr_reg;
                mem_reg.data <= bufd[pick];
                addr_reg     <= addr_reg + adbc_pkg::ADDR_W'(adbc_pkg::ADDR_STEP);
            end
            if (start) begin
                addr_reg <= i_start_addr;
            end
        end
    end

    // readback and outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            rdata_reg <= (i_sfr.rd && i_sfr.addr == adbc_pkg::CTRL_ADDR) ? ctrl_reg : 8'h00;
            irq_reg   <= irq_next;
        end
    end

    assign o_sfr_rdata = rdata_reg;
    assign o_mem       = mem_reg;
    assign o_busy      = busy_reg;
    assign o_mode      = adbc_pkg::adbc_mode_t'(ctrl_reg[adbc_pkg::BIT_MODE]);
    assign o_irq       = irq_reg;
endmodule
`default_nettype wire

// ### adbc_pkg.sv
package adbc_pkg;
    // register location and layout
    localparam logic [7:0] CTRL_ADDR      = 8'hD8;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam int         BIT_ENABLE     = 7;
    localparam int         BIT_COMPLETE   = 6;
    localparam int         BIT_MODE       = 5;
    localparam int         BIT_ERR1       = 4;
    localparam int         BIT_ERR0       = 3;
    localparam int         BIT_WARN_EN    = 2;
    localparam int         BIT_WARN1      = 1;
    localparam int         BIT_WARN0      = 0;
    localparam int         DATA_W         = 16;
    localparam int         ADDR_W         = 16;
    localparam logic [1:0] ADDR_STEP      = 2'h2;

    typedef enum logic [0:0] {
        ADBC_MODE_0 = 1'b0,
        ADBC_MODE_1 = 1'b1
    } adbc_mode_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [7:0]        addr;
        logic [7:0]        wdata;
    } adbc_sfr_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } adbc_mem_t;
endpackage

// ### adbc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module adbc_chan (
    // clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    // converter side
    input  wire logic                         i_run,
    input  wire logic                         i_ready,
    input  wire logic [adbc_pkg::DATA_W-1:0]  i_data,
    // memory side
    input  wire logic                         i_taken,
    output logic                              o_full,
    output logic [adbc_pkg::DATA_W-1:0]       o_buf,
    // events
    output logic                              o_warn,
    output logic                              o_err
);
    logic [adbc_pkg::DATA_W-1:0] hold_reg;
    logic                        hold_valid_reg;
    logic [adbc_pkg::DATA_W-1:0] buf_reg;
    logic                        full_reg;

    wire buf_free   = !full_reg || i_taken;
    // a held word goes first so words reach memory in order
    wire load_new   = i_run && i_ready && buf_free && !hold_valid_reg;
    wire load_hold  = i_run && hold_valid_reg && buf_free;
    wire park       = i_run && i_ready && (!buf_free || hold_valid_reg);
    wire lose       = park && hold_valid_reg && !load_hold;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_reg       <= '0;
            hold_valid_reg <= 1'b0;
            buf_reg        <= '0;
            full_reg       <= 1'b0;
            o_warn         <= 1'b0;
            o_err          <= 1'b0;
        end else begin
            if (load_new) begin
                buf_reg <= i_data;
            end else if (load_hold) begin
                buf_reg <= hold_reg;
            end
            if (load_new || load_hold) begin
                full_reg <= 1'b1;
            end else if (i_taken || !i_run) begin
                full_reg <= 1'b0;
            end
            if (park) begin
                hold_reg <= i_data;
            end
            hold_valid_reg <= i_run && (park || (hold_valid_reg && !load_hold));
            o_warn <= park;
            o_err  <= lose;
        end
    end

    assign o_full = full_reg;
    assign o_buf  = buf_reg;
endmodule
`default_nettype wire

// ### adbc_conv.sv
`timescale 1ns/1ps
`default_nettype none
module adbc_conv (
    // clock and request
    input  wire logic                        i_clk,
    input  wire logic                        i_fire,
    input  wire logic [adbc_pkg::DATA_W-1:0] i_word,
    // result
    output logic                             o_ready,
    output logic [adbc_pkg::DATA_W-1:0]      o_data
);
    initial begin
        o_ready = 1'b0;
        o_data  = '0;
    end
    // data line scrambled between results
    always @(posedge i_clk) begin
        o_ready <= i_fire;
        o_data  <= i_fire ? i_word : ~o_data;
    end
endmodule
`default_nettype wire

// ### adbc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adbc_checker (
    // inputs
    input wire logic                 i_clk,
    input wire logic                 i_rst,
    input wire adbc_pkg::adbc_sfr_t  i_sfr,
    input wire logic                 i_conv0_ready,
    input wire logic                 i_conv1_ready,
    input wire logic                 i_ops_done,
    input wire logic                 i_mem_grant,
    // outputs
    input wire logic [7:0]           o_sfr_rdata,
    input wire adbc_pkg::adbc_mem_t  o_mem,
    input wire logic                 o_busy,
    input wire adbc_pkg::adbc_mode_t o_mode,
    input wire logic                 o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic wr_c  = i_sfr.wr && i_sfr.addr == adbc_pkg::CTRL_ADDR;
    wire logic rd_c  = i_sfr.rd && i_sfr.addr == adbc_pkg::CTRL_ADDR;
    wire logic quiet = !(i_conv0_ready || i_conv1_ready || i_ops_done);
    sequence s_fed; o_busy && i_conv0_ready && !wr_c ##1 (i_mem_grant && !wr_c) [*2]; endsequence
    sequence s_clr; wr_c && i_sfr.wdata == 8'h00 && quiet ##1 (quiet && !wr_c) [*2]; endsequence
    a_start_busy: assert property (wr_c && i_sfr.wdata[7] && !i_ops_done ##1 !wr_c && !i_ops_done |=> o_busy)
        else $error("busy missing after start");
    a_stop_idle: assert property (wr_c && !i_sfr.wdata[7] ##1 !wr_c |=> !o_busy)
        else $error("busy kept after stop");
    a_mode_bit: assert property (wr_c ##1 !wr_c |=> o_mode == $past(i_sfr.wdata[5], 2))
        else $error("mode differs from written bit");
    a_rdata_zero: assert property (!rd_c |=> o_sfr_rdata == 8'h00)
        else $error("read data without read");
    a_req_single: assert property (o_mem.req |=> !o_mem.req)
        else $error("memory writes back to back");
    a_req_granted: assert property (o_mem.req |-> $past(i_mem_grant))
        else $error("memory write without grant");
    a_grant_write: assert property (s_fed |-> ##[0:1] o_mem.req)
        else $error("buffered word not written");
    a_irq_clear: assert property (s_clr |=> !o_irq)
        else $error("interrupt kept after flags cleared");
endmodule
`default_nettype wire

// ### adbc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adbc_top_test;
    localparam logic [7:0] CA = adbc_pkg::CTRL_ADDR;
    logic                 i_clk = 1'b0;
    logic                 i_rst = 1'b1;
    logic                 i_ops_done = 1'b0;
    logic                 i_mem_grant = 1'b1;
    logic [15:0]          i_start_addr = 16'h0000;
    adbc_pkg::adbc_sfr_t  i_sfr = '0;
    logic [1:0]           fire = 2'h0;
    logic [1:0]           rdy;
    logic [31:0]          dat;
    logic [15:0]          word = 16'h0000;
    logic [15:0]          addr;
    logic [7:0]           rd_data, b;
    logic                 irq, busy;
    adbc_pkg::adbc_mem_t  mem;
    adbc_pkg::adbc_mode_t mode;
    logic [31:0]          mq [$];
    logic [8:0]           rq [$];
    int                   failures = 0;
    int                   checked = 0;
    always #4 i_clk = ~i_clk;
    adbc_conv adbc_conv_i [1:0] (.i_clk(i_clk), .i_fire(fire), .i_word(word), .o_ready(rdy), .o_data(dat));
    adbc_top adbc_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_sfr(i_sfr), .o_sfr_rdata(rd_data),
        .i_conv0_ready(rdy[0]), .i_conv0_data(dat[15:0]), .i_conv1_ready(rdy[1]), .i_conv1_data(dat[31:16]),
        .i_ops_done(i_ops_done), .i_start_addr(i_start_addr), .i_mem_grant(i_mem_grant), .o_mem(mem),
        .o_busy(busy), .o_mode(mode), .o_irq(irq));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_mem(input logic [31:0] e, input logic [31:0] s);
        cmp("mem word", e, s);
    endtask
    task automatic cmp_ctrl(input logic [31:0] e, input logic [31:0] s);
        cmp("control", e, s);
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_sfr = '{1'b1, 1'b0, a, d};
        @(negedge i_clk);
        i_sfr = '0;
    endtask
    task automatic rd(input logic [7:0] e);
        rq.push_back({e[6] | e[4] | e[3] | (e[2] & |e[1:0]), e});
        @(negedge i_clk);
        i_sfr = '{1'b0, 1'b1, CA, 8'h00};
        @(negedge i_clk);
        i_sfr = '0;
    endtask
    task automatic conv(input int c, input logic keep);
        @(negedge i_clk);
        word = 16'($urandom);
        fire[c] = 1'b1;
        if (keep) push();
        @(negedge i_clk);
        fire[c] = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask
    task automatic push;
        mq.push_back({addr, word});
        addr += 16'(adbc_pkg::ADDR_STEP);
    endtask
    // results checked in order of appearance
    always @(posedge i_clk) begin
        #1;
        if (mem.req === 1'b1) cmp_mem(mq.size() ? mq.pop_front() : 32'hX, {mem.addr, mem.data});
        if (i_sfr.rd === 1'b1) cmp_ctrl(32'(rq.pop_front()), {23'h0, irq, rd_data});
    end
    initial begin
        void'($urandom(57));
        i_start_addr = 16'($urandom) & 16'hFFFE;
        addr = i_start_addr;
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        rd(8'h00);
        wr(8'h5A, 8'hFF);
        rd(8'h00);
        wr(CA, 8'h80);
        for (int c = 0; c < 2; c++) begin
            conv(c, 1'b1);
        end
        for (int c = 0; c < 2; c++) begin
            b = c ? 8'h84 : 8'h80;
            wr(CA, b);
            i_mem_grant = 1'b0;
            conv(c, 1'b1);
            conv(c, 1'b0);
            rd(b | (8'h01 << c));
            conv(c, 1'b1);
            rd(b | (8'h09 << c));
            i_mem_grant = 1'b1;
            repeat (6) @(negedge i_clk);
        end
        wr(CA, 8'hA0);
        rd(8'hA0);
        i_ops_done = 1'b1;
        repeat (4) @(negedge i_clk);
        i_ops_done = 1'b0;
        rd(8'h60);
        wr(CA, 8'h00);
        rd(8'h00);
        conv(0, 1'b0);
        repeat (10) @(negedge i_clk);
        cmp("words left", 32'h0, 32'(mq.size()));
        conclude();
    end
    initial begin
        #20000;
        failures++;
        conclude();
    end
endmodule
bind adbc_top adbc_checker adbc_checker_i (.i_clk(i_clk), .i_rst(i_rst), .i_sfr(i_sfr),
    .i_conv0_ready(i_conv0_ready), .i_conv1_ready(i_conv1_ready), .i_ops_done(i_ops_done),
    .i_mem_grant(i_mem_grant), .o_sfr_rdata(o_sfr_rdata), .o_mem(o_mem), .o_busy(o_busy),
    .o_mode(o_mode), .o_irq(o_irq));
`default_nettype wire
